// File: core/usdp_consts.vh
// constants for the shadow data port: register map, field positions, resets, depths
`ifndef USDP_CONSTS_VH
`define USDP_CONSTS_VH

`define USDP_ADDR_DATA       32'h5000105c
`define USDP_ADDR_CTRL       32'h500010a0
`define USDP_ADDR_STAT       32'h500010a4

`define USDP_DATA_W          8
`define USDP_REG_W           16
`define USDP_DATA_RESET      8'h00

`define USDP_CTRL_FIFO_EN    0
`define USDP_CTRL_IR_MODE    1
`define USDP_CTRL_RESET      2'h0

`define USDP_STAT_RX_READY   0
`define USDP_STAT_OVERRUN    1
`define USDP_STAT_TX_EMPTY   5
`define USDP_STAT_TX_FULL    6
`define USDP_STAT_RX_FULL    7

`define USDP_FIFO_DEPTH      16
`define USDP_FIFO_AW         4

`define USDP_HTRANS_NONSEQ   2'h2
`define USDP_HRESP_OKAY      1'h0

`endif

// File: core/usdp_fifo.v
// synchronous flip-flop fifo with flush, used for both receive and transmit queues
`default_nettype none

module usdp_fifo #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          flush,
  input  wire          push,
  input  wire [W-1:0]  din,
  input  wire          pop,
  output wire [W-1:0]  dout,
  output wire          empty,
  output wire          full
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  integer      i;

  function [AW-1:0] next_ptr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
        next_ptr = {AW{1'b0}};
      end else begin
        next_ptr = p + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  wire do_pop  = pop & ~empty;
  // a push while full is only taken when a pop frees the slot in the same cycle
  wire do_push = push & (~full | do_pop);

  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign full  = (cnt_q == DEPTH[AW:0]);
  assign dout  = mem[rd_q];

  always @(posedge clk) begin
    if (rst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {W{1'b0}};
      end
    end else if (do_push && !flush) begin
      mem[wr_q] <= din;
    end
  end

  always @(posedge clk) begin
    if (rst || flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_q <= next_ptr(wr_q);
      end
      if (do_pop) begin
        rd_q <= next_ptr(rd_q);
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule
`default_nettype wire

// File: core/usdp_skid.v
// two-entry buffer between the transmit queue and the serialiser, outputs from flops
`default_nettype none

module usdp_skid #(
  parameter W = 8
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          in_valid,
  output reg           in_ready,
  input  wire [W-1:0]  in_data,
  output reg           out_valid,
  input  wire          out_ready,
  output reg  [W-1:0]  out_data
);

  reg [W-1:0] spare_q;
  reg         spare_v_q;

  wire take = in_valid & in_ready;
  wire give = out_valid & out_ready;

  always @(posedge clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_data  <= {W{1'b0}};
      spare_q   <= {W{1'b0}};
      spare_v_q <= 1'b0;
      in_ready  <= 1'b1;
    end else begin
      if (!out_valid || give) begin
        // output slot frees: refill from the spare first to keep order
        if (spare_v_q) begin
          out_valid <= 1'b1;
          out_data  <= spare_q;
          spare_v_q <= take;
          spare_q   <= in_data;
          in_ready  <= ~take;
        end else begin
          out_valid <= take;
          out_data  <= take ? in_data : out_data;
          in_ready  <= 1'b1;
        end
      end else if (take) begin
        // receiver stalled: park the word rather than lose it
        spare_v_q <= 1'b1;
        spare_q   <= in_data;
        in_ready  <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: core/usdp_top.v
// shadow receive/transmit data port of a serial port, with an ahb-lite register slave
//
// Notes on behaviour
// R01: one 32-bit alias of the shared data path
// R02: read low byte gives line or infrared character
// R03: software trusts read data only when ready
// R04: no fifo: unread byte overwritten, overrun flagged
// R05: fifo on: read returns and pops oldest
// R06: full receive fifo drops new, flags overrun
// R07: write low byte queues line or infrared character
// R08: software writes only while holding-empty set
// R09: no fifo: a write clears holding-empty
// R10: no fifo: extra writes overwrite pending character
// R11: fifo on: accepts depth characters before full; with the serialiser stalled the two-entry buffer takes two more first
// R12: write while transmit fifo full is dropped
// R13: bits 15:8 read zero, writes ignored
//
// Register access over AHB-Lite was chosen for this implementation.
`include "usdp_consts.vh"
`default_nettype none

module usdp_top #(
  parameter FIFO_DEPTH = `USDP_FIFO_DEPTH,
  parameter FIFO_AW    = `USDP_FIFO_AW
) (
  input  wire        CORE_CLK,
  input  wire        RESET,
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output reg  [31:0] HRDATA,
  output reg         HREADYOUT,
  output reg         HRESP,
  input  wire        RX_LINE_VALID,
  input  wire [7:0]  RX_LINE_DATA,
  input  wire        RX_IR_VALID,
  input  wire [7:0]  RX_IR_DATA,
  output wire        TX_VALID,
  output wire [7:0]  TX_DATA,
  input  wire        TX_READY,
  output reg         TX_IR_SEL
);

  localparam SEL_NONE = 2'h0;
  localparam SEL_DATA = 2'h1;
  localparam SEL_CTRL = 2'h2;
  localparam SEL_STAT = 2'h3;

  // control reset pattern at its own width, so each bit can be picked out
  localparam [1:0] CTRL_RST = `USDP_CTRL_RESET;

  // control state
  reg        fifo_en_q;
  reg        ir_mode_q;

  // single-character receive buffer used while fifos are off
  reg [7:0]  rx_buffer_q;
  reg        rx_buffer_full_q;

  // single transmit holding register used while fifos are off
  reg [7:0]  tx_holding_q;
  reg        tx_holding_full_q;

  reg        overrun_q;

  // ahb data-phase bookkeeping
  reg        wr_pend_q;
  reg [1:0]  wr_sel_q;

  reg [31:0] rdata_d;
  reg        overrun_d;

  // address decode, full 32-bit compare
  function [1:0] decode;
    input [31:0] a;
    begin
      if (a == `USDP_ADDR_DATA) begin
        decode = SEL_DATA;
      end else if (a == `USDP_ADDR_CTRL) begin
        decode = SEL_CTRL;
      end else if (a == `USDP_ADDR_STAT) begin
        decode = SEL_STAT;
      end else begin
        decode = SEL_NONE;
      end
    end
  endfunction

  // only the low byte of a data-port write carries a character
  function [7:0] low_byte;
    input [31:0] w;
    begin
      low_byte = w[7:0];
    end
  endfunction

  // two-way byte select: receive source, transmit feed and data read-back
  function [7:0] pick8;
    input       sel;
    input [7:0] when_set;
    input [7:0] when_clear;
    begin
      if (sel) begin
        pick8 = when_set;
      end else begin
        pick8 = when_clear;
      end
    end
  endfunction

  // status word as software sees it; bits not listed read zero
  function [31:0] status_word;
    input ready;
    input ovr;
    input tx_empty;
    input tx_full;
    input rx_full;
    begin
      status_word                      = 32'h0000_0000;
      status_word[`USDP_STAT_RX_READY] = ready;
      status_word[`USDP_STAT_OVERRUN]  = ovr;
      status_word[`USDP_STAT_TX_EMPTY] = tx_empty;
      status_word[`USDP_STAT_TX_FULL]  = tx_full;
      status_word[`USDP_STAT_RX_FULL]  = rx_full;
    end
  endfunction

  // control word read-back
  function [31:0] ctrl_word;
    input fifo_en;
    input ir_mode;
    begin
      ctrl_word                     = 32'h0000_0000;
      ctrl_word[`USDP_CTRL_FIFO_EN] = fifo_en;
      ctrl_word[`USDP_CTRL_IR_MODE] = ir_mode;
    end
  endfunction

  wire        accept   = HSEL & HTRANS[1] & HREADY;
  wire [1:0]  a_sel    = decode(HADDR);
  wire        rd_data  = accept & ~HWRITE & (a_sel == SEL_DATA); // [R01]
  wire        rd_stat  = accept & ~HWRITE & (a_sel == SEL_STAT);
  wire        wr_data  = wr_pend_q & (wr_sel_q == SEL_DATA);     // [R01]
  wire        wr_ctrl  = wr_pend_q & (wr_sel_q == SEL_CTRL);

  // a change of fifo mode empties both queues and both single buffers; words already in the two-entry buffer still go out
  wire        mode_flip = wr_ctrl & (HWDATA[`USDP_CTRL_FIFO_EN] != fifo_en_q);

  // receive character source follows the mode bit
  wire        rx_valid = ir_mode_q ? RX_IR_VALID : RX_LINE_VALID; // [R02]
  wire [7:0]  rx_char  = pick8(ir_mode_q, RX_IR_DATA, RX_LINE_DATA); // [R02]

  // receive fifo
  wire [7:0]  rxf_dout;
  wire        rxf_empty;
  wire        rxf_full;
  wire        rxf_pop  = fifo_en_q & rd_data & ~rxf_empty;         // [R05]
  wire        rxf_push = fifo_en_q & rx_valid;                     // [R06]

  usdp_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .flush (mode_flip),
    .push  (rxf_push),
    .din   (rx_char),
    .pop   (rxf_pop),
    .dout  (rxf_dout),
    .empty (rxf_empty),
    .full  (rxf_full)
  );

  // transmit fifo; txf_push is gated off while full, since the fifo itself takes a push when full if a pop frees a slot
  wire [7:0]  txf_dout;
  wire        txf_empty;
  wire        txf_full;
  wire        txb_in_ready;
  wire        txf_push = fifo_en_q & wr_data & ~txf_full;          // [R11] [R12]
  wire        txf_pop  = fifo_en_q & txb_in_ready & ~txf_empty;

  usdp_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .clk   (CORE_CLK),
    .rst   (RESET),
    .flush (mode_flip),
    .push  (txf_push),
    .din   (low_byte(HWDATA)),                                     // [R07]
    .pop   (txf_pop),
    .dout  (txf_dout),
    .empty (txf_empty),
    .full  (txf_full)
  );

  // the two-entry buffer keeps words when the serialiser stalls
  wire        txb_in_valid = fifo_en_q ? ~txf_empty : tx_holding_full_q;
  wire [7:0]  txb_in_data  = pick8(fifo_en_q, txf_dout, tx_holding_q);

  usdp_skid #(
    .W (8)
  ) u_tx_buf (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .in_valid  (txb_in_valid),
    .in_ready  (txb_in_ready),
    .in_data   (txb_in_data),
    .out_valid (TX_VALID),
    .out_ready (TX_READY),
    .out_data  (TX_DATA)
  );

  wire        holding_taken = ~fifo_en_q & tx_holding_full_q & txb_in_ready;

  // flags seen by software
  wire        rx_data_ready    = fifo_en_q ? ~rxf_empty : rx_buffer_full_q;
  wire        tx_holding_empty = fifo_en_q ? txf_empty : ~tx_holding_full_q;

  // a character is lost when it arrives with nowhere to go
  wire        rx_lost_plain = ~fifo_en_q & rx_valid & rx_buffer_full_q & ~rd_data; // [R04]
  wire        rx_lost_fifo  = fifo_en_q & rx_valid & rxf_full & ~rxf_pop;         // [R06]

  // overrun: set by either mode's loss case, cleared by a status read; set wins
  always @* begin
    overrun_d = overrun_q;
    if (rd_stat) begin
      overrun_d = 1'b0;
    end
    if (rx_lost_plain) begin
      overrun_d = 1'b1;                                            // [R04]
    end
    if (rx_lost_fifo) begin
      overrun_d = 1'b1;                                            // [R06]
    end
  end

  // read data is captured in the address phase so the data phase needs no wait
  always @* begin
    rdata_d = 32'h0000_0000;
    case (a_sel)
      SEL_DATA: begin
        // upper bits of the port always read zero
        rdata_d[7:0] = pick8(fifo_en_q, rxf_dout, rx_buffer_q);    // [R02] [R05] [R13]
      end
      SEL_CTRL: begin
        rdata_d = ctrl_word(fifo_en_q, ir_mode_q);
      end
      SEL_STAT: begin
        rdata_d = status_word(rx_data_ready, overrun_q, tx_holding_empty,
                              fifo_en_q & txf_full, fifo_en_q & rxf_full);
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // ahb-lite slave: zero wait states, always okay
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      HREADYOUT <= 1'b1;
      HRESP     <= `USDP_HRESP_OKAY;
      wr_pend_q <= 1'b0;
      wr_sel_q  <= SEL_NONE;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= `USDP_HRESP_OKAY;
      wr_pend_q <= accept & HWRITE;
      wr_sel_q  <= accept ? a_sel : SEL_NONE;
    end
  end

  // read data loads only on a read accept and then stands until the next one
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      HRDATA <= 32'h0000_0000;
    end else if (accept && !HWRITE) begin
      HRDATA <= rdata_d;
    end
  end

  // control register
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      fifo_en_q <= CTRL_RST[`USDP_CTRL_FIFO_EN];
      ir_mode_q <= CTRL_RST[`USDP_CTRL_IR_MODE];
    end else if (wr_ctrl) begin
      fifo_en_q <= HWDATA[`USDP_CTRL_FIFO_EN];
      ir_mode_q <= HWDATA[`USDP_CTRL_IR_MODE];
    end
  end

  // serialiser output select is its own flop so the pin comes straight from a register
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      TX_IR_SEL <= CTRL_RST[`USDP_CTRL_IR_MODE];
    end else if (wr_ctrl) begin
      TX_IR_SEL <= HWDATA[`USDP_CTRL_IR_MODE];                     // [R07]
    end
  end

  // single receive buffer while fifos are off
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      rx_buffer_q      <= `USDP_DATA_RESET;
      rx_buffer_full_q <= 1'b0;
    end else if (mode_flip) begin
      rx_buffer_full_q <= 1'b0;
    end else if (!fifo_en_q) begin
      if (rx_valid) begin
        // a new character replaces an unread one; arrival beats a same-cycle read
        rx_buffer_q      <= rx_char;                               // [R04]
        rx_buffer_full_q <= 1'b1;
      end else if (rd_data) begin
        rx_buffer_full_q <= 1'b0;
      end
    end
  end

  // single transmit holding register while fifos are off
  always @(posedge CORE_CLK) begin
    if (RESET) begin
      tx_holding_q      <= `USDP_DATA_RESET;
      tx_holding_full_q <= 1'b0;
    end else if (mode_flip) begin
      tx_holding_full_q <= 1'b0;
    end else if (!fifo_en_q) begin
      if (wr_data) begin
        // a write while still pending overwrites the waiting character
        tx_holding_q      <= low_byte(HWDATA);                     // [R09] [R10] [R13]
        tx_holding_full_q <= 1'b1;                                 // [R09]
      end else if (holding_taken) begin
        tx_holding_full_q <= 1'b0;
      end
    end
  end

  always @(posedge CORE_CLK) begin
    if (RESET) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= overrun_d;
    end
  end

  // hsize is unused: only whole-word single transfers are supported
  wire unused_ok = &{1'b0, HSIZE, HWDATA[31:8], HTRANS[0]};

endmodule
`default_nettype wire

// File: verification/usdp_chk.sv
// assertion checker watching the shadow data port top level ports
`include "usdp_consts.vh"
`default_nettype none
module usdp_chk (
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        TX_VALID,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_READY,
  input wire logic        TX_IR_SEL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);
  // hready is tied to hreadyout, so hreadyout stands in for it here
  wire rd  = HSEL && HTRANS[1] && !HWRITE && HREADYOUT;
  wire ctl = HSEL && HTRANS[1] && HWRITE && HADDR == `USDP_ADDR_CTRL;
  wire unm = HADDR != `USDP_ADDR_DATA && HADDR != `USDP_ADDR_CTRL
             && HADDR != `USDP_ADDR_STAT;
  AST_READY: assert property (HREADYOUT)
    else $error("hreadyout low");
  AST_OKAY: assert property (!HRESP)
    else $error("hresp not okay");
  AST_DATA_HI: assert property (rd && HADDR == `USDP_ADDR_DATA |=> HRDATA[31:8] == 24'h0)
    else $error("data read upper bits set");
  AST_UNMAP: assert property (rd && unm |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!rd |=> $stable(HRDATA))
    else $error("read data moved without a read");
  AST_TX_HOLD: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("stalled tx character lost");
  AST_IR_ON: assert property (ctl ##1 HWDATA[1] |-> ##[1:2] TX_IR_SEL)
    else $error("infrared select not set");
  AST_IR_OFF: assert property (ctl ##1 !HWDATA[1] |-> ##[1:2] !TX_IR_SEL)
    else $error("infrared select not cleared");
endmodule
`default_nettype wire

// File: verification/usdp_peer.sv
// far-side transceiver model: delivers received characters, drains the transmitter
`default_nettype none
module usdp_peer (
  input  wire logic       clk,
  input  wire logic       stall,
  output var  logic       line_valid,
  output var  logic [7:0] line_data,
  output var  logic       ir_valid,
  output var  logic [7:0] ir_data,
  output var  logic       tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  int         seed = 32'ha9bdaa00;
  initial begin
    line_valid = 1'b0;
    ir_valid   = 1'b0;
    line_data  = 8'h0;
    ir_data    = 8'h0;
    tx_ready   = 1'b0;
  end
  // ready drops at random so both prompt and slow draining occur
  always @(posedge clk) begin
    tx_ready <= !stall && ($random(seed) % 4 != 0);
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  end
  task automatic send(input bit ir, input logic [7:0] b);
    @(posedge clk);
    ir_valid   <= ir;
    line_valid <= !ir;
    ir_data    <= b;
    line_data  <= b;
    @(posedge clk);
    ir_valid   <= 1'b0;
    line_valid <= 1'b0;
    // idle data inverted so a stale byte is never mistaken for a fresh one
    ir_data    <= ~b;
    line_data  <= ~b;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_usdp_top.sv
// self-checking bench for the shadow data port
`include "usdp_consts.vh"
`default_nettype none
module tb_usdp_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int D = 4;
  logic        clk = 0;
  logic        rst = 1;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        stall = 1;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] r;
  logic [31:0] d;
  logic [7:0]  q[$];
  wire  [31:0] hrdata;
  wire         hready, hresp, lv, iv, txv, txr, irs;
  wire  [7:0]  ld, id, txd;
  int          n_errors = 0;
  int          num_checks = 0;
  int          seed = 32'ha9bdaa00;
  int          i;
  always #2 clk = ~clk;
  usdp_top #(.FIFO_DEPTH(D), .FIFO_AW(2)) i_usdp_top (
    .CORE_CLK(clk), .RESET(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .RX_LINE_VALID(lv), .RX_LINE_DATA(ld), .RX_IR_VALID(iv), .RX_IR_DATA(id),
    .TX_VALID(txv), .TX_DATA(txd), .TX_READY(txr), .TX_IR_SEL(irs));
  usdp_peer i_usdp_peer (
    .clk(clk), .stall(stall), .line_valid(lv), .line_data(ld), .ir_valid(iv),
    .ir_data(id), .tx_ready(txr), .tx_valid(txv), .tx_data(txd));
  function automatic logic [31:0] word(input logic [7:0] b);
    return {24'h0, b};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hw;
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (hready === 1'b1)
        break;
    end
    if (hready !== 1'b1) begin
      n_errors++;
      give_verdict;
    end
  endtask
  task automatic xfer(input bit w, input logic [31:0] a, dt);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= `USDP_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    hw();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dt;
    hw();
    r = hrdata;
  endtask
  task automatic drain(input int n);
    int k;
    for (k = 0; k < 300 && i_usdp_peer.got.size() < n; k++)
      @(posedge clk);
    // extra cycles so a dropped write that leaked out would show
    repeat (20) @(posedge clk);
    chk("tx count", i_usdp_peer.got.size(), n);
    foreach (q[j])
      chk("tx byte", i_usdp_peer.got[j], q[j]);
    q.delete();
    i_usdp_peer.got.delete();
    if (k == 300)
      give_verdict;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    xfer(1, 32'h50001100, 32'hffffffff);
    xfer(0, 32'h50001100, 0);
    chk("unmapped", r, 32'h0);
    xfer(0, `USDP_ADDR_DATA, 0);
    chk("data reset", r, 32'h0);
    xfer(0, `USDP_ADDR_STAT, 0);
    chk("stat reset", r & 32'h23, 32'h20);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      xfer(1, `USDP_ADDR_DATA, d);
      if (i != 2)
        q.push_back(d[7:0]);
      repeat (3) @(posedge clk);
      xfer(0, `USDP_ADDR_STAT, 0);
      chk("holding empty", r[5], i < 2);
    end
    stall <= 1'b0;
    drain(3);
    $display("plain transmit done");
    stall <= 1'b1;
    xfer(1, `USDP_ADDR_CTRL, 32'h1);
    for (i = 0; i < D + 3; i++) begin
      d = $random(seed);
      xfer(1, `USDP_ADDR_DATA, d);
      if (i < D + 2)
        q.push_back(d[7:0]);
    end
    xfer(0, `USDP_ADDR_STAT, 0);
    chk("tx full", r[6], 1'b1);
    stall <= 1'b0;
    drain(D + 2);
    $display("fifo transmit done");
    for (i = 0; i <= D; i++) begin
      d = $random(seed);
      i_usdp_peer.send(0, d[7:0]);
      q.push_back(d[7:0]);
    end
    xfer(0, `USDP_ADDR_STAT, 0);
    chk("rx full overrun", r & 32'h83, 32'h83);
    for (i = 0; i < D; i++) begin
      xfer(0, `USDP_ADDR_DATA, 0);
      chk("rx head", r, word(q[i]));
    end
    q.delete();
    xfer(0, `USDP_ADDR_STAT, 0);
    chk("rx drained", r & 32'h3, 32'h0);
    $display("fifo receive done");
    xfer(1, `USDP_ADDR_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk("ir select", irs, 1'b1);
    d = $random(seed);
    i_usdp_peer.send(1, 8'h3c);
    i_usdp_peer.send(1, d[7:0]);
    i_usdp_peer.send(0, ~d[7:0]);
    xfer(0, `USDP_ADDR_STAT, 0);
    chk("rx overrun", r & 32'h3, 32'h3);
    xfer(0, `USDP_ADDR_DATA, 0);
    chk("ir char", r, word(d[7:0]));
    xfer(1, `USDP_ADDR_DATA, d);
    q.push_back(d[7:0]);
    drain(1);
    $display("infrared done");
    give_verdict;
  end
endmodule
bind usdp_top usdp_chk i_usdp_chk (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
  .TX_IR_SEL(TX_IR_SEL));
`default_nettype wire
